// [cbm_can_node.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Far-side node: sends one byte-long frame MSB first, recessive between frames
module cbm_can_node (
	input wire logic ref_clk_i,
	input wire logic send_i,
	input wire logic [7:0] frame_i,
	input wire logic [15:0] bit_clks_i,
	output logic rx_o,
	output logic busy_o
);
	logic [7:0] sh_q; // Bits still to send
	logic [3:0] left_q; // Count of bits left
	logic [15:0] cnt_q; // Clocks into current bit
	// Idle bus is recessive, as the pull-up would leave it
	initial begin
		rx_o = 1'b1;
		busy_o = 1'b0;
		sh_q = 8'hFF;
		left_q = 4'h0;
		cnt_q = 16'h0000;
	end
	// Bit shifter
	always @(posedge ref_clk_i) begin
		if (send_i && !busy_o) begin
			sh_q <= frame_i;
			left_q <= 4'h8;
			cnt_q <= 16'h0000;
			busy_o <= 1'b1;
			rx_o <= frame_i[7];
		end else if (busy_o) begin
			if (cnt_q == bit_clks_i - 16'h0001) begin
				// Next bit, or release the bus after the last one
				cnt_q <= 16'h0000;
				left_q <= left_q - 4'h1;
				sh_q <= {sh_q[6:0], 1'b1};
				rx_o <= (left_q == 4'h1) ? 1'b1 : sh_q[6];
				busy_o <= (left_q != 4'h1);
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule : cbm_can_node

// [cbm_pkg.sv]
package cbm_pkg;
	// Register port geometry
	localparam int unsigned CBM_ADDR_W = 4;
	localparam int unsigned CBM_DATA_W = 16;
	// Register addresses
	localparam logic [3:0] CBM_OFS_BTC = 4'h0; // bit_timing_config
	localparam logic [3:0] CBM_OFS_MDC = 4'h2; // mailbox_direction_config
	localparam logic [3:0] CBM_OFS_CTL = 4'h4; // reset_request_control
	localparam logic [3:0] CBM_OFS_STA = 4'h6; // timing status
	// Values after reset
	localparam logic [15:0] CBM_BTC_RST = 16'h0000;
	localparam logic [15:0] CBM_MDC_RST = 16'h0100;
	localparam logic CBM_RRQ_RST = 1'b1;
	// Field positions of bit_timing_config
	localparam int unsigned CBM_SJW_LSB = 14;
	localparam int unsigned CBM_BRP_LSB = 8;
	localparam int unsigned CBM_BSP_BIT = 7;
	localparam int unsigned CBM_TS2_LSB = 4;
	localparam int unsigned CBM_TS1_LSB = 0;
	// Field positions of mailbox_direction_config
	localparam int unsigned CBM_MDC_RSV = 8;
	localparam int unsigned CBM_MDC_LO_LSB = 9;
	// Field positions of control and status
	localparam int unsigned CBM_CTL_RRQ = 0;
	localparam int unsigned CBM_STA_RST = 0;
	localparam int unsigned CBM_STA_BIT = 1;
	localparam int unsigned CBM_STA_ST = 2;
	// Mailbox count
	localparam int unsigned CBM_MBX_N = 15;
	// Bit timing states, Gray along sync, seg1, seg2
	typedef enum logic [1:0] {
		CBM_IDLE = 2'b10,
		CBM_SYNC = 2'b00,
		CBM_SEG1 = 2'b01,
		CBM_SEG2 = 2'b11
	} cbm_state_t;
endpackage : cbm_pkg

// [cbm_sync3.sv]
`timescale 1ns/1ns
module cbm_sync3 (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic d_i,
	output logic q_o
);
	import cbm_pkg::*;
	////////////////////////////////////////////////////////////////////
	logic ff1_q, ff2_q, ff3_q; // Synchroniser chain
	logic val_q, val_d; // Accepted level
	// Accept when second and third stage agree
	always_comb begin
		val_d = val_q;
		if (ff2_q == ff3_q) begin
			val_d = ff3_q;
		end
	end
	// Chain and held value, recessive after reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ff1_q <= 1'b1;
			ff2_q <= 1'b1;
			ff3_q <= 1'b1;
			val_q <= 1'b1;
		end else if (ce_i) begin
			ff1_q <= d_i;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
			val_q <= val_d;
		end
	end
	assign q_o = val_q;
endmodule : cbm_sync3

// [cbm_top.sv]
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
module cbm_top (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [cbm_pkg::CBM_ADDR_W-1:0] addr_i,
	input wire logic [cbm_pkg::CBM_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [cbm_pkg::CBM_DATA_W-1:0] rdata_o,
	input wire logic rx_pin_i,
	output logic [cbm_pkg::CBM_MBX_N:1] mailbox_rx_o,
	output logic reset_mode_o,
	output logic bit_start_o,
	output logic sample_valid_o,
	output logic sample_bit_o
);
	import cbm_pkg::*;
	////////////////////////////////////////////////////////////////////
	// Register file
	logic [15:0] btc_q, btc_d; // bit_timing_config
	logic [15:0] mdc_q, mdc_d; // mailbox_direction_config
	logic rrq_q, rrq_d; // reset_request_control
	logic [15:0] rdata_q, rdata_d; // Read data, one cycle after strobe
	// Decoded fields
	logic [1:0] resync_jump_width; // resync_jump_width
	logic [5:0] quantum_prescaler; // quantum_prescaler
	logic sample_point_select; // sample_point_select
	logic [2:0] ts2; // time_segment_two
	logic [3:0] ts1; // time_segment_one
	// Bit timing state
	cbm_state_t st_q, st_d; // Segment state
	logic [4:0] cnt_q, cnt_d; // Quanta elapsed in segment
	logic [2:0] ext_q, ext_d; // Segment one lengthening
	logic [2:0] shr_q, shr_d; // Segment two shortening
	logic rsy_q, rsy_d; // Resync already done this bit
	logic [2:0] smp_q, smp_d; // Early, middle, late samples
	logic bit_q, bit_d; // Resolved bit
	logic vld_q, vld_d; // Sample valid pulse
	logic bst_q, bst_d; // Bit start pulse
	logic rxp_q, rxp_d; // Previous synced receive level
	// Wires
	logic rx_s; // Synchronised receive level
	logic tq; // Quantum tick
	logic edge_f; // Recessive to dominant edge
	logic [4:0] seg1_lim; // Current segment one length
	logic [4:0] seg2_lim; // Current segment two length
	logic [2:0] jmp; // Jump width in quanta

	////////////////////////////////////////////////////////////////////
	// Majority of three samples
	function automatic logic cbm_vote(input logic [2:0] s);
		cbm_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : cbm_vote

	// Smaller of two quanta counts
	function automatic logic [2:0] cbm_min(input logic [4:0] a, input logic [2:0] b);
		if (a < {2'b00, b}) begin
			cbm_min = a[2:0];
		end else begin
			cbm_min = b;
		end
	endfunction : cbm_min

	////////////////////////////////////////////////////////////////////
	// Field decode
	always_comb begin
		resync_jump_width = btc_q[CBM_SJW_LSB +: 2];
		quantum_prescaler = btc_q[CBM_BRP_LSB +: 6];
		sample_point_select = btc_q[CBM_BSP_BIT];
		ts2 = btc_q[CBM_TS2_LSB +: 3];
		ts1 = btc_q[CBM_TS1_LSB +: 4];
		jmp = {1'b0, resync_jump_width} + 3'd1;
		seg1_lim = {1'b0, ts1} + 5'd1 + {2'b00, ext_q};
		seg2_lim = {2'b00, ts2} + 5'd1 - {2'b00, shr_q};
	end

	////////////////////////////////////////////////////////////////////
	// Register writes and reads
	always_comb begin
		btc_d = btc_q;
		mdc_d = mdc_q;
		rrq_d = rrq_q;
		rdata_d = 16'h0000;
		if (wr_i) begin
			if (addr_i == CBM_OFS_BTC) begin
				btc_d = wdata_i;
			end else if (addr_i == CBM_OFS_MDC) begin
				mdc_d = wdata_i;
				mdc_d[CBM_MDC_RSV] = 1'b1;
			end else if (addr_i == CBM_OFS_CTL) begin
				rrq_d = wdata_i[CBM_CTL_RRQ];
			end
		end
		if (rd_i) begin
			if (addr_i == CBM_OFS_BTC) begin
				rdata_d = btc_q;
			end else if (addr_i == CBM_OFS_MDC) begin
				rdata_d = mdc_q;
			end else if (addr_i == CBM_OFS_CTL) begin
				rdata_d[CBM_CTL_RRQ] = rrq_q;
			end else if (addr_i == CBM_OFS_STA) begin
				rdata_d[CBM_STA_RST] = (st_q == CBM_IDLE);
				rdata_d[CBM_STA_BIT] = bit_q;
				rdata_d[CBM_STA_ST +: 2] = st_q;
			end
		end
	end

	// Register state, controller starts in reset mode
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			btc_q <= CBM_BTC_RST;
			mdc_q <= CBM_MDC_RST;
			rrq_q <= CBM_RRQ_RST;
			rdata_q <= 16'h0000;
		end else if (ce_i) begin
			btc_q <= btc_d;
			mdc_q <= mdc_d;
			rrq_q <= rrq_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive pin synchroniser
	cbm_sync3 u_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i(rx_pin_i),
		.q_o(rx_s)
	);

	// Quantum generator, stopped in reset mode
	cbm_tq_gen #(
		.BRP_W(6)
	) u_tq (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.run_i(!rrq_q),
		.brp_i(quantum_prescaler),
		.tick_o(tq)
	);

	////////////////////////////////////////////////////////////////////
	// Bit timing: segments, resync and sampling
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ext_d = ext_q;
		shr_d = shr_q;
		rsy_d = rsy_q;
		smp_d = smp_q;
		bit_d = bit_q;
		vld_d = 1'b0;
		bst_d = 1'b0;
		rxp_d = rx_s;
		edge_f = rxp_q & !rx_s;
		if (rrq_q) begin
			// Reset mode holds the engine idle
			st_d = CBM_IDLE;
			cnt_d = '0;
			ext_d = '0;
			shr_d = '0;
			rsy_d = 1'b0;
		end else begin
			// Resynchronise on an edge once per bit
			if (edge_f && !rsy_q) begin
				if (st_q == CBM_SEG1) begin
					ext_d = cbm_min(cnt_q + 5'd1, jmp);
					rsy_d = 1'b1;
				end else if (st_q == CBM_SEG2) begin
					shr_d = cbm_min(seg2_lim - cnt_q, jmp);
					rsy_d = 1'b1;
				end
			end
			if (tq) begin
				case (st_q)
					CBM_IDLE: begin
						// Leave reset mode at a bit start
						st_d = CBM_SYNC;
						bst_d = 1'b1;
					end
					CBM_SYNC: begin
						// One synchronisation quantum
						st_d = CBM_SEG1;
						cnt_d = '0;
					end
					CBM_SEG1: begin
						cnt_d = cnt_q + 5'd1;
						// Early sample one quantum before the point
						if (cnt_q + 5'd2 == seg1_lim) begin
							smp_d[0] = rx_s;
						end
						if (cnt_q + 5'd1 >= seg1_lim) begin
							// Sample point at end of segment one
							smp_d[1] = rx_s;
							st_d = CBM_SEG2;
							cnt_d = '0;
							if (!sample_point_select) begin
								bit_d = rx_s;
								vld_d = 1'b1;
							end
						end
					end
					CBM_SEG2: begin
						cnt_d = cnt_q + 5'd1;
						// Late sample one quantum after the point
						if (cnt_q == 5'd0 && sample_point_select) begin
							smp_d[2] = rx_s;
							bit_d = cbm_vote({rx_s, smp_q[1:0]});
							vld_d = 1'b1;
						end
						if (cnt_q + 5'd1 >= seg2_lim) begin
							// Next bit begins
							st_d = CBM_SYNC;
							cnt_d = '0;
							ext_d = '0;
							shr_d = '0;
							rsy_d = 1'b0;
							bst_d = 1'b1;
						end
					end
					default: begin
						st_d = CBM_IDLE;
					end
				endcase
			end
		end
	end

	// Bit timing registers
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= CBM_IDLE;
			cnt_q <= '0;
			ext_q <= '0;
			shr_q <= '0;
			rsy_q <= 1'b0;
			smp_q <= 3'h7;
			bit_q <= 1'b1;
			vld_q <= 1'b0;
			bst_q <= 1'b0;
			rxp_q <= 1'b1;
		end else if (ce_i) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ext_q <= ext_d;
			shr_q <= shr_d;
			rsy_q <= rsy_d;
			smp_q <= smp_d;
			bit_q <= bit_d;
			vld_q <= vld_d;
			bst_q <= bst_d;
			rxp_q <= rxp_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdata_o = rdata_q;
	assign mailbox_rx_o = {mdc_q[7:0], mdc_q[15:CBM_MDC_LO_LSB]};
	assign reset_mode_o = rrq_q;
	assign bit_start_o = bst_q;
	assign sample_valid_o = vld_q;
	assign sample_bit_o = bit_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Clocks since the last quantum tick, enabled cycles only
	logic [7:0] gap_q;
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_q <= '0;
		end else if (ce_i) begin
			// Generator starts counting one clock after reset mode ends
			if (rrq_q) begin
				gap_q <= 8'h00;
			end else if (tq) begin
				gap_q <= 8'h01;
			end else begin
				gap_q <= gap_q + 8'h01;
			end
		end
	end

	sequence s_mdc_write;
		ce_i && wr_i && addr_i == CBM_OFS_MDC;
	endsequence
	sequence s_mdc_read;
		ce_i && rd_i && addr_i == CBM_OFS_MDC;
	endsequence
	sequence s_seg1_tick;
		ce_i && tq && !rrq_q && st_q == CBM_SEG1;
	endsequence
	sequence s_seg2_tick;
		ce_i && tq && !rrq_q && st_q == CBM_SEG2;
	endsequence

	a_rsvd_reads_one: assert property (s_mdc_read |=> rdata_o[CBM_MDC_RSV])
		else $error("reserved direction bit did not read one");
	a_mbx_swap_map: assert property (s_mdc_write |=>
		mailbox_rx_o[1] == $past(wdata_i[9]) && mailbox_rx_o[8] == $past(wdata_i[0]))
		else $error("mailbox direction mapping wrong");
	a_tq_period: assert property (ce_i && tq && !rrq_q && gap_q > 8'd1 && $stable(quantum_prescaler)
		|-> gap_q == {1'b0, quantum_prescaler, 1'b1} + 8'd1)
		else $error("quantum period wrong");
	a_seg1_hold: assert property (s_seg1_tick ##0 (cnt_q + 5'd1 < seg1_lim)
		|=> st_q == CBM_SEG1)
		else $error("segment one ended early");
	a_seg2_hold: assert property (s_seg2_tick ##0 (cnt_q + 5'd1 < seg2_lim)
		|=> st_q == CBM_SEG2)
		else $error("segment two ended early");
	a_single_point: assert property (ce_i && sample_valid_o && !sample_point_select && !rrq_q
		|-> st_q == CBM_SEG2 && cnt_q == 5'd0)
		else $error("single sample not at end of segment one");
	a_triple_vote: assert property (ce_i && sample_valid_o && sample_point_select && !rrq_q
		|-> sample_bit_o == cbm_vote(smp_q))
		else $error("triple sample vote wrong");
	a_jump_bound: assert property (ext_q <= jmp && shr_q <= jmp)
		else $error("resync exceeded jump width");
	a_reset_idle: assert property (ce_i && rrq_q ##1 ce_i |-> st_q == CBM_IDLE)
		else $error("engine ran in reset mode");
	a_sync_to_seg1: assert property (ce_i && tq && !rrq_q && st_q == CBM_SYNC
		|=> st_q == CBM_SEG1 || rrq_q)
		else $error("sync quantum not followed by segment one");
endmodule : cbm_top

// [cbm_tq_gen.sv]
`timescale 1ns/1ns
module cbm_tq_gen #(
	parameter int unsigned BRP_W = 6
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic [BRP_W-1:0] brp_i,
	output logic tick_o
);
	import cbm_pkg::*;
	////////////////////////////////////////////////////////////////////
	logic [BRP_W:0] cnt_q, cnt_d; // Clock counter inside a quantum
	logic tick_q, tick_d; // Quantum end pulse
	logic [BRP_W:0] lim; // Last count, 2*(n+1)-1
	// Period of 2*(n+1) clocks
	always_comb begin
		lim = {brp_i, 1'b1};
		cnt_d = cnt_q + 1'b1;
		tick_d = 1'b0;
		if (!run_i) begin
			cnt_d = '0;
		end else if (cnt_q >= lim) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end
	// Register counter and pulse
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick_o = tick_q;
endmodule : cbm_tq_gen

// [testbench.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the timing and mailbox configuration block
module testbench;
	import cbm_pkg::*;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, send = 1'b0, ce = 1'b1;
	logic rx, busy, rmode, bstart, svalid, sbit;
	logic [3:0] addr_i = 4'h0;
	// Node bit is 10 quanta of 4 clocks, matching the frame test timing
	logic [15:0] wdata_i = 16'h0000, rdata_o, bits = 16'h0028;
	logic [7:0] frame = 8'h00;
	logic [15:1] mbx;
	int miscompares = 0, tests_run = 0, cyc = 0;
	// Clock, 50 ns period
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) cyc <= cyc + 1;
	cbm_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i(rx),
		.mailbox_rx_o(mbx), .reset_mode_o(rmode), .bit_start_o(bstart),
		.sample_valid_o(svalid), .sample_bit_o(sbit));
	cbm_can_node node (.ref_clk_i(ref_clk_i), .send_i(send), .frame_i(frame),
		.bit_clks_i(bits), .rx_o(rx), .busy_o(busy));
	////////////////////////////////////////////////////////////////////////////////
	// Register port master
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// Bounded wait for a bit start or sample pulse, returns its cycle
	task automatic await(input bit sv, output int t);
		for (int n = 0; n < 20000; n++) begin
			@(posedge ref_clk_i);
			#1;
			if (sv ? svalid === 1'b1 : bstart === 1'b1) begin
				t = cyc;
				return;
			end
		end
		miscompares++;
		$display("[FAIL] pulse expected 1 seen none");
		wrap_up();
	endtask : await
	// Mailbox n direction bit position, byte-swapped
	function automatic logic [15:0] mbx_exp(input logic [15:0] d);
		mbx_exp = 16'h0000;
		for (int m = 1; m <= 15; m++) mbx_exp[m] = (m < 8) ? d[m + 8] : d[m - 8];
	endfunction : mbx_exp
	// Program timing in reset mode, release, measure bit and sample spacing
	task automatic timing(input logic [1:0] resync_jump_width, input logic [5:0] quantum_prescaler, input logic sample_point_select,
		input logic [2:0] t2, input logic [3:0] t1);
		int a, b, c, tq;
		tq = 2 * (quantum_prescaler + 1);
		wr(CBM_OFS_CTL, 16'h0001);
		wr(CBM_OFS_BTC, {resync_jump_width, quantum_prescaler, sample_point_select, t2, t1});
		wr(CBM_OFS_CTL, 16'h0000);
		await(1'b0, a);
		chk("reset_mode", 16'h0000, {15'h0000, rmode});
		await(1'b1, b);
		await(1'b0, c);
		chk("bit_len", 16'((t1 + t2 + 3) * tq), 16'(c - a));
		chk("sample_at", 16'((t1 + 2 + sample_point_select) * tq), 16'(b - a));
		$display("test timing brp %0d done", quantum_prescaler);
	endtask : timing
	// Far node sends a random frame; count dominant bits resolved
	task automatic frame_test(input logic sample_point_select);
		int z;
		timing(2'h3, 6'h01, sample_point_select, 3'h2, 4'h5);
		@(posedge ref_clk_i);
		frame <= 8'($urandom);
		send <= 1'b1;
		@(posedge ref_clk_i);
		send <= 1'b0;
		z = 0;
		for (int n = 0; n < 400; n++) begin
			@(posedge ref_clk_i);
			#1;
			if (svalid === 1'b1 && sbit === 1'b0) z++;
		end
		chk("zeros", 16'(8 - $countones(frame)), 16'(z));
		$display("test frame sampling %0d done", sample_point_select);
	endtask : frame_test
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [15:0] d, q;
		int n;
		d = 16'($urandom(32'h7E0A6BCF));
		repeat (4) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		#1 chk("rst_mbx", 16'h0000, {mbx, 1'b0});
		chk("rst_mode", 16'h0001, {15'h0000, rmode});
		chk("rst_sample", 16'h0001, {15'h0000, sbit});
		rd(CBM_OFS_BTC, q);
		chk("btc_rst", 16'h0000, q);
		rd(CBM_OFS_MDC, q);
		chk("mdc_rst", 16'h0100, q);
		rd(CBM_OFS_CTL, q);
		chk("ctl_rst", 16'h0001, q & 16'h0001);
		// Status: idle state code 10, resolved bit 1, engine idle
		rd(CBM_OFS_STA, q);
		chk("sta_rst", 16'h000B, q);
		wr(4'h8, 16'hFFFF);
		rd(4'h8, q);
		chk("unmapped", 16'h0000, q);
		$display("test reset values done");
		// Direction register, bit 8 written low in the first corner
		for (int i = 0; i < 10; i++) begin
			d = (i == 0) ? 16'hFEFF : (i == 1) ? 16'h0100 : 16'($urandom);
			wr(CBM_OFS_MDC, d);
			rd(CBM_OFS_MDC, q);
			chk("mdc", d | 16'h0100, q);
			chk("mbx", mbx_exp(d), {mbx, 1'b0});
		end
		// Clock enable low: a write strobe must be ignored
		@(posedge ref_clk_i);
		ce <= 1'b0;
		wr(CBM_OFS_MDC, ~d);
		ce <= 1'b1;
		rd(CBM_OFS_MDC, q);
		chk("ce_hold", d | 16'h0100, q);
		chk("ce_mbx", mbx_exp(d), {mbx, 1'b0});
		$display("test direction done");
		// Bit timing fields store whole
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 16'hFFFF : 16'($urandom);
			wr(CBM_OFS_BTC, d);
			rd(CBM_OFS_BTC, q);
			chk("btc", d, q);
		end
		$display("test timing register done");
		timing(2'h0, 6'h00, 1'b0, 3'h1, 4'h3);
		timing(2'h3, 6'h3F, 1'b1, 3'h7, 4'hF);
		for (int i = 0; i < 3; i++) begin
			timing(2'($urandom), 6'($urandom % 8), 1'($urandom), 3'(1 + $urandom % 7),
				4'(3 + $urandom % 13));
		end
		// Reset request stops the engine
		wr(CBM_OFS_CTL, 16'h0001);
		n = 0;
		repeat (400) begin
			@(posedge ref_clk_i);
			#1;
			if (bstart !== 1'b0) n++;
		end
		chk("halt_mode", 16'h0001, {15'h0000, rmode});
		chk("halt_pulses", 16'h0000, 16'(n));
		$display("test reset mode done");
		frame_test(1'b0);
		frame_test(1'b1);
		wrap_up();
	end
endmodule : testbench
